// ==== bench/cfg_source_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfg_source_model
    import cfg_seq_pkg::*;
(
    input  wire logic         sys_clk,    // system clock
    output logic              data_valid, // byte or bit present
    output logic [BYTE_W-1:0] data_in     // byte, bit 0 when serial
);
    initial
    begin
        data_valid = 1'b0;
        data_in    = 8'h00;
    end

    // bytes first, first+1, ...; serial schemes go lsb first on bit 0
    task automatic send(input logic [2:0] sch, input logic [7:0] first, input int n,
                        input bit slow);
        logic [7:0] b;
        int         nb;
        nb = (sch == 3'h1 || sch == 3'h4) ? 8 : 1;
        for (int i = 0; i < n; i++)
        begin
            b = first + 8'(i);
            for (int k = 0; k < nb; k++)
            begin
                @(negedge sys_clk);
                data_valid <= 1'b1;
                data_in    <= (nb == 8) ? {~data_in[7:1], b[k]} : b;
                // strobed scheme needs a low gap; slow host idles between units
                if (sch == 3'h2 || slow)
                begin
                    @(negedge sys_clk);
                    data_valid <= 1'b0;
                    data_in    <= ~data_in;
                end
            end
        end
        @(negedge sys_clk);
        // released bus shows the inverse so a stale byte never reads as good
        data_valid <= 1'b0;
        data_in    <= ~data_in;
    endtask : send
endmodule : cfg_source_model
`default_nettype wire

// ==== bench/sram_config_sequencer_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module sram_config_sequencer_bench;
    import cfg_seq_pkg::*;
    localparam int NW  = 4;
    localparam int LIM = 400;

    logic        sys_clk            = 1'b0;
    logic        reset              = 1'b1;
    logic        reconfig_request_n = 1'b1;
    logic        test_reconfig_cmd  = 1'b0;
    logic        chain_enable_in_n  = 1'b0;
    logic [2:0]  scheme_select      = 3'h3;
    logic [1:0]  cfg_read_addr      = 2'h0;
    logic        pll_src_pins       = 1'b0;
    logic        pll_logic_shift    = 1'b0;
    logic        pll_logic_bit      = 1'b0;
    logic        pll_logic_update   = 1'b0;
    logic        pll_pin_shift      = 1'b0;
    logic        pll_pin_bit        = 1'b0;
    logic        pll_pin_update     = 1'b0;
    logic        data_valid;
    logic [7:0]  data_in;
    logic        command_mode;
    logic        user_mode;
    logic        io_enable;
    logic        internal_reset;
    logic        conf_done;
    logic        chain_enable_out_n;
    logic        data_ready;
    logic        config_error;
    logic [7:0]  cfg_read_data;
    logic [8:0]  pll_mult;
    logic [8:0]  pll_div;
    logic [3:0]  pll_delay;
    int          bad_count          = 0;
    int          tests_run          = 0;
    int          cycles             = 0;

    always #20 sys_clk = ~sys_clk;

    sram_config_sequencer #(.N_WORDS(NW), .LIMIT_CYCLES(LIM)) i_dut (
        .sys_clk(sys_clk), .reset(reset), .reconfig_request_n(reconfig_request_n),
        .test_reconfig_cmd(test_reconfig_cmd), .chain_enable_in_n(chain_enable_in_n),
        .scheme_select(scheme_select), .data_valid(data_valid), .data_in(data_in),
        .cfg_read_addr(cfg_read_addr), .pll_src_pins(pll_src_pins),
        .pll_logic_shift(pll_logic_shift), .pll_logic_bit(pll_logic_bit),
        .pll_logic_update(pll_logic_update), .pll_pin_shift(pll_pin_shift),
        .pll_pin_bit(pll_pin_bit), .pll_pin_update(pll_pin_update),
        .command_mode(command_mode), .user_mode(user_mode), .io_enable(io_enable),
        .internal_reset(internal_reset), .conf_done(conf_done),
        .chain_enable_out_n(chain_enable_out_n), .data_ready(data_ready),
        .config_error(config_error), .cfg_read_data(cfg_read_data),
        .pll_mult(pll_mult), .pll_div(pll_div), .pll_delay(pll_delay));

    cfg_source_model i_src (.sys_clk(sys_clk), .data_valid(data_valid), .data_in(data_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    task automatic wait_ready();
        for (int n = 0; n < 60 && data_ready !== 1'b1; n++)
            @(negedge sys_clk);
        check(data_ready, 1, "ready");
    endtask : wait_ready

    task automatic restart(input bit via_test);
        @(negedge sys_clk);
        test_reconfig_cmd  = via_test;
        reconfig_request_n = via_test;
        @(negedge sys_clk);
        test_reconfig_cmd  = 1'b0;
        reconfig_request_n = 1'b1;
        @(negedge sys_clk);
        check(user_mode, 0, "user after restart");
        check(io_enable, 0, "io after restart");
        check({conf_done, chain_enable_out_n}, 2'b01, "done after restart");
    endtask : restart

    // loads NW words, follows init into user mode, reads the store back
    task automatic load_check(input logic [2:0] sch, input logic [7:0] first, input bit slow);
        scheme_select = sch;
        wait_ready();
        i_src.send(sch, first, NW, slow);
        @(negedge sys_clk);
        check({conf_done, chain_enable_out_n}, 2'b10, "loaded");
        check({io_enable, internal_reset, command_mode}, 3'b011, "init");
        for (int n = 0; n < 20 && user_mode !== 1'b1; n++)
            @(negedge sys_clk);
        check({user_mode, io_enable, internal_reset, command_mode}, 4'b1100, "user");
        for (int a = 0; a < NW; a++)
        begin
            cfg_read_addr = 2'(a);
            @(negedge sys_clk);
            check(cfg_read_data, first + 8'(a), "store");
        end
    endtask : load_check

    task automatic refused_loads();
        restart(1'b0);
        chain_enable_in_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(data_ready, 0, "chain held");
        i_src.send(3'h3, 8'h50, NW, 1'b0);
        check(conf_done, 0, "chain refused");
        chain_enable_in_n = 1'b0;
        scheme_select     = 3'h5;
        i_src.send(3'h5, 8'h58, NW, 1'b0);
        check(conf_done, 0, "bad scheme");
        load_check(3'h3, 8'h60, 1'b0);
    endtask : refused_loads

    task automatic budget_overrun();
        int n;
        restart(1'b0);
        wait_ready();
        for (n = 0; n < LIM + 40 && config_error !== 1'b1; n++)
            @(negedge sys_clk);
        check(config_error, 1, "overrun");
        check(n > LIM - 4 && n < LIM + 4, 1, "budget length");
        check(io_enable, 0, "io in overrun");
        repeat (3) @(negedge sys_clk);
        wait_ready();
        check(config_error, 0, "error cleared");
        load_check(3'h3, 8'h90, 1'b0);
    endtask : budget_overrun

    // the unselected source shifts the inverse frame to expose a wrong mux
    task automatic pll_load(input logic [21:0] f, input bit pins, input bit live);
        logic [21:0] old;
        old          = {pll_mult, pll_div, pll_delay};
        pll_src_pins = pins;
        for (int i = 0; i < 22; i++)
        begin
            @(negedge sys_clk);
            pll_logic_shift = 1'b1;
            pll_pin_shift   = 1'b1;
            pll_logic_bit   = f[i] ^ pins;
            pll_pin_bit     = f[i] ^ !pins;
        end
        @(negedge sys_clk);
        pll_logic_shift  = 1'b0;
        pll_pin_shift    = 1'b0;
        pll_logic_update = 1'b1;
        pll_pin_update   = 1'b1;
        check(user_mode, live, "user during pll");
        @(negedge sys_clk);
        pll_logic_update = 1'b0;
        pll_pin_update   = 1'b0;
        check({pll_mult, pll_div, pll_delay}, old, "pll early");
        @(negedge sys_clk);
        check({pll_mult, pll_div, pll_delay}, live ? f : old, "pll");
        check(io_enable, live, "io during pll");
    endtask : pll_load

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end

    initial
    begin
        repeat (4) @(negedge sys_clk);
        check({io_enable, command_mode, user_mode}, 3'b010, "in reset");
        repeat (12) @(negedge sys_clk);
        reset = 1'b0;
        repeat (5) @(negedge sys_clk);
        check({data_ready, io_enable, conf_done}, 3'b000, "power up");
        load_check(3'h3, 8'h10, 1'b0);
        for (int s = 0; s < 5; s++)
        begin
            restart(s == 4);
            load_check(3'(s), 8'h20 + 8'(s * 16), s == 0);
        end
        restart(1'b0);
        scheme_select = 3'h3;
        wait_ready();
        i_src.send(3'h3, 8'h70, 2, 1'b0);
        restart(1'b0);
        load_check(3'h3, 8'h80, 1'b0);
        refused_loads();
        budget_overrun();
        pll_load(22'h2a5c3e, 1'b0, 1'b1);
        pll_load(22'h15a3c1, 1'b1, 1'b1);
        restart(1'b1);
        pll_load(22'h0f0f0f, 1'b0, 1'b0);
        load_check(3'h3, 8'ha0, 1'b0);
        complete_run();
    end
endmodule : sram_config_sequencer_bench
`default_nettype wire

// ==== hw/cfg_seq_pkg.sv ====
package cfg_seq_pkg;

    typedef enum logic [2:0]
    {
        config_device_scheme,
        passive_serial_scheme,
        passive_parallel_async_scheme,
        fast_parallel_scheme,
        test_port_scheme
    } scheme_t;

    typedef enum logic [2:0]
    {
        st_power_up,
        st_wait_request,
        st_loading,
        st_init,
        st_user
    } seq_state_t;

    localparam int BYTE_W          = 8;
    localparam int CONFIG_WORDS    = 16;
    localparam int POWER_UP_CYCLES = 16;
    localparam int INIT_CYCLES     = 8;

    // load budget: 100 ms, longest time so rounded down
    localparam int    CONFIG_LIMIT_MS     = 100;
    localparam longint SYS_CLK_HZ         = 64'h17d_7840;
    localparam longint MS_PER_S           = 64'h3e8;
    localparam int    CONFIG_LIMIT_CYCLES =
        int'(longint'(CONFIG_LIMIT_MS) * SYS_CLK_HZ / MS_PER_S);

    // fastest feed: one byte per 10 ns, budget 100 ms
    localparam longint FAST_FEED_WORDS_MAX = 64'h98_9680;

    localparam int PLL_MULT_W  = 9;
    localparam int PLL_DIV_W   = 9;
    localparam int PLL_DELAY_W = 4;
    localparam logic [PLL_MULT_W-1:0]  PLL_MULT_RESET  = 9'h001;
    localparam logic [PLL_DIV_W-1:0]   PLL_DIV_RESET   = 9'h001;
    localparam logic [PLL_DELAY_W-1:0] PLL_DELAY_RESET = 4'h0;

endpackage : cfg_seq_pkg

// ==== hw/pll_chain_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface pll_chain_if
    import cfg_seq_pkg::*;
();
    logic                   shift_en;
    logic                   shift_bit;
    logic                   update;
    logic [PLL_MULT_W-1:0]  mult;
    logic [PLL_DIV_W-1:0]   div;
    logic [PLL_DELAY_W-1:0] delay;

    modport chain (input shift_en, shift_bit, update, output mult, div, delay);
    modport ctrl  (output shift_en, shift_bit, update, input mult, div, delay);
endinterface : pll_chain_if
`default_nettype wire

// ==== hw/pll_counter_chain.sv ====
`timescale 1ns/1ns
`default_nettype none
module pll_counter_chain
    import cfg_seq_pkg::*;
(
    input  wire logic  sys_clk, // system clock
    input  wire logic  reset,   // synchronous, active high
    pll_chain_if.chain bus      // shift chain and live counters
);
    localparam int CHAIN_W = PLL_MULT_W + PLL_DIV_W + PLL_DELAY_W;

    logic [CHAIN_W-1:0] chain;

    // shadow chain lets new settings shift in while old ones stay live
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            chain <= '0;
        else if (bus.shift_en)
            chain <= {bus.shift_bit, chain[CHAIN_W-1:1]};
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            bus.mult  <= PLL_MULT_RESET;
            bus.div   <= PLL_DIV_RESET;
            bus.delay <= PLL_DELAY_RESET;
        end
        else if (bus.update)
        begin
            {bus.mult, bus.div, bus.delay} <= chain;
        end
    end

    pll_update_a: assert property (@(posedge sys_clk) disable iff (reset)
        bus.update |=> {bus.mult, bus.div, bus.delay} == $past(chain))
        else $error("pll counters did not take the shifted chain");

endmodule : pll_counter_chain
`default_nettype wire

// ==== hw/sram_config_sequencer.sv ====
// Function
// - user I/O stays high impedance at power-up and before and during loading
// - after loading: clear internal registers, release I/O, then run
// - two top states: command mode (power-up, wait, load plus init) and user mode
// - a dedicated pin forces user mode back to command mode, reload, rerun
// - volatile configuration must be loaded again after every power-up
// - five load schemes: memory device, serial, async parallel, fast parallel, test port
// - devices chain: chain enable out feeds next device chain enable in
// - byte-wide load at 100 MHz finishes in under 100 ms
// - a host may feed data serially or parallel, strobed or clocked
// - PLL multiply, divide, delay reloadable over a serial chain from logic or pins
// - all other logic keeps running in user mode during PLL reload
// - request pin low or test port command restarts configuration
`timescale 1ns/1ns
`default_nettype none
module sram_config_sequencer
    import cfg_seq_pkg::*;
#(
    parameter int N_WORDS      = CONFIG_WORDS,
    parameter int LIMIT_CYCLES = CONFIG_LIMIT_CYCLES
)(
    input  wire logic                    sys_clk,            // system clock
    input  wire logic                    reset,              // synchronous, active high
    input  wire logic                    reconfig_request_n, // low requests reload
    input  wire logic                    test_reconfig_cmd,  // test port reload command
    input  wire logic                    chain_enable_in_n,  // low lets this device load
    input  wire logic [2:0]              scheme_select,      // load scheme
    input  wire logic                    data_valid,         // data strobe / valid
    input  wire logic [BYTE_W-1:0]       data_in,            // data, bit 0 when serial
    input  wire logic [$clog2(N_WORDS)-1:0] cfg_read_addr,   // config store read address
    input  wire logic                    pll_src_pins,       // 1: chain fed from pins
    input  wire logic                    pll_logic_shift,    // logic-side shift enable
    input  wire logic                    pll_logic_bit,      // logic-side shift bit
    input  wire logic                    pll_logic_update,   // logic-side update
    input  wire logic                    pll_pin_shift,      // pin-side shift enable
    input  wire logic                    pll_pin_bit,        // pin-side shift bit
    input  wire logic                    pll_pin_update,     // pin-side update
    output logic                         command_mode,       // power-up, waiting, loading or initialising
    output logic                         user_mode,          // normal operation
    output logic                         io_enable,          // user I/O may drive
    output logic                         internal_reset,     // clears user registers
    output logic                         conf_done,          // store fully loaded
    output logic                         chain_enable_out_n, // enables next device
    output logic                         data_ready,         // loading with chain enabled; scheme not checked
    output logic                         config_error,       // load overran budget
    output logic [BYTE_W-1:0]            cfg_read_data,      // config store word
    output logic [PLL_MULT_W-1:0]        pll_mult,           // live multiply count
    output logic [PLL_DIV_W-1:0]         pll_div,            // live divide count
    output logic [PLL_DELAY_W-1:0]       pll_delay           // live delay count
);
    localparam int WORD_W   = $clog2(N_WORDS);
    localparam int BUDGET_W = $clog2(LIMIT_CYCLES + 1);
    localparam int PHASE_W  = $clog2(POWER_UP_CYCLES + INIT_CYCLES);
    localparam int BIT_W    = $clog2(BYTE_W);
    localparam logic [WORD_W-1:0]   LAST_WORD   = WORD_W'(N_WORDS - 1);
    localparam logic [BUDGET_W-1:0] LIMIT_LAST  = BUDGET_W'(LIMIT_CYCLES - 1);
    localparam logic [PHASE_W-1:0]  POWER_LAST  = PHASE_W'(POWER_UP_CYCLES - 1);
    localparam logic [PHASE_W-1:0]  INIT_LAST   = PHASE_W'(INIT_CYCLES - 1);
    localparam logic [BIT_W-1:0]    LAST_BIT    = BIT_W'(BYTE_W - 1);

    // serial worst case must still fit the budget at this clock
    if (N_WORDS < 2 || longint'(N_WORDS) >= FAST_FEED_WORDS_MAX ||
        N_WORDS * BYTE_W >= LIMIT_CYCLES || POWER_UP_CYCLES < 1 || INIT_CYCLES < 1)
    begin : bad_params
        $error("sram_config_sequencer: parameters out of range");
    end

    seq_state_t             state;
    seq_state_t             next_state;
    logic [PHASE_W-1:0]     phase_cnt;
    logic [WORD_W-1:0]      word_cnt;
    logic [BUDGET_W-1:0]    budget_cnt;
    logic [BIT_W-1:0]       bit_cnt;
    logic [BYTE_W-1:0]      shift_byte;
    logic                   strobe_q;
    logic [BYTE_W-1:0]      cfg_mem [N_WORDS];
    scheme_t                scheme;
    logic                   scheme_ok;
    logic                   serial;
    logic                   restart;
    logic                   take;
    logic                   byte_done;
    logic                   budget_last;
    logic [BYTE_W-1:0]      next_byte;

    pll_chain_if pll ();

    assign scheme      = scheme_t'(scheme_select);
    assign scheme_ok   = scheme_select <= 3'(test_port_scheme);
    assign serial      = scheme == passive_serial_scheme || scheme == test_port_scheme;
    assign restart     = !reconfig_request_n || test_reconfig_cmd;
    assign budget_last = budget_cnt == LIMIT_LAST;

    // strobed parallel takes one byte per rising strobe; others take per valid cycle
    always_comb
    begin
        take = 1'b0;
        if (state == st_loading && !chain_enable_in_n && scheme_ok)
        begin
            if (scheme == passive_parallel_async_scheme)
                take = data_valid && !strobe_q;
            else
                take = data_valid;
        end
    end

    assign byte_done = take && (!serial || bit_cnt == LAST_BIT);
    assign next_byte = serial ? {data_in[0], shift_byte[BYTE_W-1:1]} : data_in;

    always_comb
    begin
        next_state = state;
        case (state)
            st_power_up:
                if (phase_cnt == POWER_LAST)
                    next_state = st_wait_request;
            st_wait_request:
                if (!restart)
                    next_state = st_loading;
            st_loading:
                if (restart || budget_last)
                    next_state = st_wait_request;
                else if (byte_done && word_cnt == LAST_WORD)
                    next_state = st_init;
            st_init:
                if (restart)
                    next_state = st_wait_request;
                else if (phase_cnt == INIT_LAST)
                    next_state = st_user;
            st_user:
                if (restart)
                    next_state = st_wait_request;
            default:
                next_state = st_power_up;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            state <= st_power_up;
        else
            state <= next_state;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset || next_state != state)
            phase_cnt <= '0;
        else if (state == st_power_up || state == st_init)
            phase_cnt <= phase_cnt + 1'b1;
    end

    // every new load starts from the first word
    always_ff @(posedge sys_clk)
    begin
        if (reset || state != st_loading)
        begin
            word_cnt <= '0;
            bit_cnt  <= '0;
        end
        else if (take)
        begin
            bit_cnt <= serial ? bit_cnt + 1'b1 : '0;
            if (byte_done)
                word_cnt <= word_cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            shift_byte <= '0;
        else if (take)
            shift_byte <= next_byte;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            strobe_q <= 1'b0;
        else
            strobe_q <= data_valid;
    end

    // budget runs only while loading, so a stalled feeder cannot hang us
    always_ff @(posedge sys_clk)
    begin
        if (reset || state != st_loading)
            budget_cnt <= '0;
        else
            budget_cnt <= budget_cnt + 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            config_error <= 1'b0;
        else if (state == st_loading && budget_last && !restart)
            config_error <= 1'b1;
        else if (state == st_wait_request && next_state == st_loading)
            config_error <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (byte_done)
            cfg_mem[word_cnt] <= next_byte;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cfg_read_data <= '0;
        else
            cfg_read_data <= cfg_mem[cfg_read_addr];
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            command_mode       <= 1'b1;
            user_mode          <= 1'b0;
            io_enable          <= 1'b0;
            internal_reset     <= 1'b1;
            conf_done          <= 1'b0;
            chain_enable_out_n <= 1'b1;
            data_ready         <= 1'b0;
        end
        else
        begin
            command_mode       <= next_state != st_user;
            user_mode          <= next_state == st_user;
            io_enable          <= next_state == st_user;
            internal_reset     <= next_state != st_user;
            conf_done          <= next_state == st_init || next_state == st_user;
            chain_enable_out_n <= !(next_state == st_init || next_state == st_user);
            data_ready         <= next_state == st_loading && !chain_enable_in_n;
        end
    end

    // PLL reload only touches the counters, never the sequencer state
    always_ff @(posedge sys_clk)
    begin
        if (reset || state != st_user)
        begin
            pll.shift_en  <= 1'b0;
            pll.shift_bit <= 1'b0;
            pll.update    <= 1'b0;
        end
        else
        begin
            pll.shift_en  <= pll_src_pins ? pll_pin_shift  : pll_logic_shift;
            pll.shift_bit <= pll_src_pins ? pll_pin_bit    : pll_logic_bit;
            pll.update    <= pll_src_pins ? pll_pin_update : pll_logic_update;
        end
    end

    pll_counter_chain u_pll_chain
    (
        .sys_clk (sys_clk),
        .reset   (reset),
        .bus     (pll.chain)
    );

    assign pll_mult  = pll.mult;
    assign pll_div   = pll.div;
    assign pll_delay = pll.delay;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_load_done;
        state == st_loading ##1 state == st_init;
    endsequence

    sequence s_user_restart;
        state == st_user && restart;
    endsequence

    io_float_cmd_a: assert property (
        state inside {st_power_up, st_wait_request, st_loading} |=> !io_enable)
        else $error("user I/O enabled outside user mode");
    init_clear_a: assert property (s_load_done |-> internal_reset && !io_enable)
        else $error("init phase did not hold clear with I/O floating");
    init_release_a: assert property (
        state == st_init && phase_cnt == INIT_LAST && !restart |=> io_enable && !internal_reset)
        else $error("init end did not release I/O");
    mode_split_a: assert property (user_mode != command_mode)
        else $error("command and user mode not exclusive");
    reload_exit_a: assert property (
        s_user_restart |=> !io_enable && command_mode ##1 word_cnt == '0)
        else $error("restart did not leave user mode cleanly");
    power_up_a: assert property (state == st_power_up |=> !conf_done && !io_enable)
        else $error("done or I/O active during power-up");
    word_step_a: assert property (
        state == st_loading && byte_done && word_cnt != LAST_WORD && !restart && !budget_last
        |=> word_cnt == $past(word_cnt) + 1'b1)
        else $error("loaded byte not counted");
    chain_out_a: assert property (!chain_enable_out_n |-> conf_done)
        else $error("next device enabled before this one loaded");
    budget_a: assert property (
        state == st_loading && budget_last && !restart |=> config_error && state == st_wait_request)
        else $error("load budget overrun not flagged");
    strobe_edge_a: assert property (
        scheme == passive_parallel_async_scheme && strobe_q |-> !take)
        else $error("held strobe took a second byte");
    pll_user_a: assert property (
        state == st_user && pll.shift_en && !restart |=> user_mode && io_enable)
        else $error("pll reload disturbed user mode");
    restart_a: assert property (
        state inside {st_loading, st_init} && restart |=> state == st_wait_request)
        else $error("request did not restart configuration");

endmodule : sram_config_sequencer
`default_nettype wire
